// ==== fss_defs.svh ====
`ifndef FSS_DEFS_SVH
`define FSS_DEFS_SVH

// ****************************************
// Clock
// ****************************************
`define FSS_CLK_MHZ 100

// ****************************************
// Timing figures in their own units
// ****************************************
`define FSS_WD_PERIOD_MS 256
`define FSS_RST_PULSE_US 1000
`define FSS_BUS_IDLE_MS 8000
`define FSS_CLAMP_MS 100

// ****************************************
// Timing counts in core_clk cycles
// ****************************************
`define FSS_WD_PERIOD_CYC (`FSS_WD_PERIOD_MS * 1000 * `FSS_CLK_MHZ)
`define FSS_RST_PULSE_CYC (`FSS_RST_PULSE_US * `FSS_CLK_MHZ)
`define FSS_BUS_IDLE_CYC (`FSS_BUS_IDLE_MS * 1000 * `FSS_CLK_MHZ)
`define FSS_CLAMP_CYC (`FSS_CLAMP_MS * 1000 * `FSS_CLK_MHZ)

// ****************************************
// Field positions and values
// ****************************************
`define FSS_WDINIT_CRANK_BIT 0
`define FSS_WDINIT_SECOND_BIT 4
`define FSS_MISC_OVERRIDE_BIT 2
`define FSS_MISC_RESET 3'h0
`define FSS_FAIL_LIMIT 4'h8
`define FSS_CLEAR_CMD_A 16'hDD00
`define FSS_CLEAR_CMD_B 16'hDD80

`endif

// ==== fss_host.sv ====
module fss_host import fss_pkg::*; (
  // Clock
  input wire logic core_clk,
  // Software health
  input wire logic keepAlive,
  // Host command side
  output logic wdRefreshOk,
  output logic spiCmdValid,
  output logic [15:0] spiCmd
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Host software model
  // ****************************************
  int gap = 0;
  logic reqRefresh = 1'b0;
  logic reqCmd = 1'b0;
  logic [15:0] cmdCode = 16'h0000;
  logic takeRefresh = 1'b0;
  logic takeCmd = 1'b0;
  logic [15:0] cmdNow = 16'h0000;

  initial begin
    wdRefreshOk = 1'b0;
    spiCmdValid = 1'b0;
    spiCmd = 16'h0000;
  end

  // Requests are taken at the edge and driven just after it, so they never race
  always @(posedge core_clk) begin
    takeRefresh = reqRefresh;
    takeCmd = reqCmd;
    cmdNow = cmdCode;
    reqRefresh = 1'b0;
    reqCmd = 1'b0;
    gap = keepAlive ? gap + 1 : 0;
    if (gap == 50) begin
      takeRefresh = 1'b1;
      gap = 0;
    end
    #1;
    wdRefreshOk = takeRefresh;
    spiCmdValid = takeCmd;
    spiCmd = takeCmd ? cmdNow : ~spiCmd; // Idle bus toggles, never holds a stale command
  end

  // A single correct watchdog refresh
  task automatic refresh();
    reqRefresh = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // Read-and-clear of the safe flags, or any other command word
  task automatic command(input logic [15:0] code);
    cmdCode = code;
    reqCmd = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
endmodule

// ==== fss_pkg.sv ====
package fss_pkg;

  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [2:0] {
    FSS_OFF = 3'h0,
    FSS_INIT_RESET = 3'h1,
    FSS_INIT = 3'h2,
    FSS_RESET = 3'h3,
    FSS_NORMAL_REQ = 3'h4,
    FSS_NORMAL = 3'h5,
    FSS_SAFE_OFF = 3'h6
  } fss_mode_t;

  // Safe mode codes, equal to the low two override bits
  typedef enum logic [1:0] {
    FSS_SAFE_B3 = 2'h0,
    FSS_SAFE_B2 = 2'h1,
    FSS_SAFE_B1 = 2'h2,
    FSS_SAFE_A = 2'h3
  } fss_safe_t;

  // ****************************************
  // Asynchronous pin and comparator levels
  // ****************************************
  typedef struct packed {
    logic batteryAboveOn;
    logic batteryPor;
    logic mcuSupplyLow;
    logic resetPinLevel;
    logic io1Level;
    logic canActivity;
    logic linWake;
    fss_safe_t debugStrapCode;
  } fss_pins_t;

  typedef struct packed {
    fss_pins_t stage1;
    fss_pins_t stage2;
  } fss_sync_t;

  typedef struct packed {
    logic [31:0] count;
  } fss_timer_t;

  typedef struct packed {
    fss_mode_t mode;
    logic vddEnable;
    logic resetOutN;
    logic safeOutN;
    logic safeState;
    logic io1WakeArmed;
    logic busIdle;
    logic batteryFailFlag;
    logic crankHold;
    logic secondPulse;
    logic [2:0] miscSel;
    fss_safe_t strapMode;
    logic [3:0] failCount;
    logic timerRestart;
  } fss_state_t;

endpackage

// ==== fss_supervisor.sv ====
`include "fss_defs.svh"

// Notes on behaviour
// - Crank hold bit is watchdog-init bit 0, resets to 0, set by write.
// - At power up the MCU regulator turns on above the battery on threshold.
// - Crank clear: supply stays on until reset; in reset, off below threshold.
// - Crank set: supply stays on until power-on reset, which sets battery fail.
// - While in the safe state the safe output is driven low.
// - Safe mode A keeps the MCU supply on until the failure recovers.
// - B1 drops supply after 8 s bus idle, B2 on I/O-1 low, B3 both.
// - Strap code is sampled on the move from init to normal mode.
// - Override codes 111/110/101/100 pick A/B1/B2/B3 and beat the strap.
// - Wake-up in safe state with supply off resumes through reset mode.
// - Safe output stays low after wake until a clear command arrives.
// - Watchdog failure drives safe low at first or second pulse, by bit 4.
// - Supply below reset threshold drops reset and safe in the same cycle.
// - Reset pin clamped low externally leads into the safe state.
// - Eight consecutive watchdog failures lead into the safe state.
// - Without refresh a 1 ms reset pulse follows every 256 ms period.
// - Recovery needs reset and supply lows cleared plus a correct refresh.
// - I/O-1 high wakes from safe state only if armed before entry.
module fss_supervisor import fss_pkg::*; #(
  parameter logic [31:0] WD_PERIOD_CYC = `FSS_WD_PERIOD_CYC,
  parameter logic [31:0] RST_PULSE_CYC = `FSS_RST_PULSE_CYC,
  parameter logic [31:0] BUS_IDLE_CYC = `FSS_BUS_IDLE_CYC,
  parameter logic [31:0] CLAMP_CYC = `FSS_CLAMP_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pins and comparators, asynchronous
  input wire fss_pins_t pinsAsync,
  // Host command side, same clock
  input wire logic wdInitWrite,
  input wire logic [7:0] wdInitData,
  input wire logic miscInitWrite,
  input wire logic [2:0] miscInitData,
  input wire logic wdRefreshOk,
  input wire logic spiCmdValid,
  input wire logic [15:0] spiCmd,
  input wire logic io1WakeEnable,
  input wire logic resetThresholdSel,
  input wire logic batteryFailClear,
  // Supply and pins
  output logic vddEnable,
  output logic resetPinOut,
  output logic resetPinOe,
  output logic safeOutN,
  output logic resetSupplyThreshold,
  // Status
  output logic batteryFailFlag,
  output logic safeStateActive,
  output fss_safe_t safeModeSel,
  output logic [3:0] failCount,
  output fss_mode_t deviceMode
);

  // ****************************************
  // Declarations
  // ****************************************
  fss_state_t r;
  fss_state_t next_r;
  fss_pins_t p;
  fss_safe_t effMode;
  logic operating;
  logic inReset;
  logic timerDone;
  logic busDone;
  logic clampDone;
  logic resetLowExt;
  logic recovered;
  logic clearCmd;
  logic wake;
  logic vddOffCond;
  logic enterSafe;
  logic [3:0] newCount;
  logic [31:0] timerLimit;

  // ****************************************
  // Input synchroniser and timers
  // ****************************************
  fss_sync u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pinsAsync(pinsAsync),
    .pinsSync(p)
  );

  // One timer serves both the refresh window and the reset pulse
  assign timerLimit = operating ? WD_PERIOD_CYC : RST_PULSE_CYC;

  fss_timer u_wd_timer (
    .core_clk(core_clk),
    .reset(reset),
    .restart(r.timerRestart || wdRefreshOk),
    .enable(operating || inReset),
    .limit(timerLimit),
    .done(timerDone)
  );

  // Bus idle span restarts on every sign of CAN traffic
  fss_timer u_bus_timer (
    .core_clk(core_clk),
    .reset(reset),
    .restart(p.canActivity),
    .enable(r.safeState && !r.busIdle),
    .limit(BUS_IDLE_CYC),
    .done(busDone)
  );

  // Reset pin clamp span; any release of the pin starts it over
  fss_timer u_clamp_timer (
    .core_clk(core_clk),
    .reset(reset),
    .restart(!resetLowExt),
    .enable(r.vddEnable && !r.safeState),
    .limit(CLAMP_CYC),
    .done(clampDone)
  );

  // ****************************************
  // Decoded conditions
  // ****************************************
  assign operating = (r.mode == FSS_INIT) || (r.mode == FSS_NORMAL_REQ) ||
    (r.mode == FSS_NORMAL);
  assign inReset = (r.mode == FSS_INIT_RESET) || (r.mode == FSS_RESET);
  // Override bits win over the strap code
  assign effMode = r.miscSel[`FSS_MISC_OVERRIDE_BIT] ?
    fss_safe_t'(r.miscSel[1:0]) : r.strapMode;
  // Pin low while we are not pulling it means someone else holds it
  assign resetLowExt = !p.resetPinLevel && r.resetOutN;
  assign recovered = !resetLowExt && !p.mcuSupplyLow && wdRefreshOk;
  assign clearCmd = spiCmdValid &&
    ((spiCmd == `FSS_CLEAR_CMD_A) || (spiCmd == `FSS_CLEAR_CMD_B));
  assign wake = p.canActivity || p.linWake || (p.io1Level && r.io1WakeArmed);
  assign enterSafe = clampDone;

  // Which external events let a B mode drop the supply
  always_comb begin
    vddOffCond = 1'b0;
    case (effMode)
      FSS_SAFE_B1: vddOffCond = r.busIdle;
      FSS_SAFE_B2: vddOffCond = !p.io1Level;
      FSS_SAFE_B3: vddOffCond = r.busIdle && !p.io1Level;
      default: vddOffCond = 1'b0;
    endcase
  end

  // Saturating count of back-to-back watchdog failures
  assign newCount = (r.failCount == `FSS_FAIL_LIMIT) ? r.failCount :
    r.failCount + 4'h1;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.timerRestart = 1'b0;
    // Configuration writes
    if (wdInitWrite) begin
      next_r.crankHold = wdInitData[`FSS_WDINIT_CRANK_BIT];
      next_r.secondPulse = wdInitData[`FSS_WDINIT_SECOND_BIT];
    end
    if (miscInitWrite) begin
      next_r.miscSel = miscInitData;
    end
    // Clears come first so that any set below wins in the same cycle
    if (clearCmd && !r.safeState) begin
      next_r.safeOutN = 1'b1;
    end
    if (batteryFailClear) begin
      next_r.batteryFailFlag = 1'b0;
    end
    if (wdRefreshOk) begin
      next_r.failCount = 4'h0;
    end
    // Mode sequencing
    case (r.mode)
      FSS_OFF: begin
        next_r.resetOutN = 1'b0;
        if (p.batteryAboveOn && !p.batteryPor) begin
          next_r.vddEnable = 1'b1;
          next_r.mode = FSS_INIT_RESET;
          next_r.timerRestart = 1'b1;
        end
      end
      FSS_INIT_RESET, FSS_RESET: begin
        next_r.resetOutN = 1'b0;
        if (!r.crankHold && !p.batteryAboveOn) begin
          next_r.vddEnable = 1'b0;
          next_r.mode = FSS_OFF;
        end else if (timerDone && !p.mcuSupplyLow) begin
          next_r.resetOutN = 1'b1;
          next_r.mode = (r.mode == FSS_INIT_RESET) ? FSS_INIT : FSS_NORMAL_REQ;
          next_r.timerRestart = 1'b1;
        end
      end
      FSS_INIT: begin
        if (wdRefreshOk) begin
          next_r.strapMode = p.debugStrapCode;
          next_r.mode = FSS_NORMAL;
        end
      end
      FSS_NORMAL_REQ: begin
        if (wdRefreshOk) begin
          next_r.mode = FSS_NORMAL;
        end
      end
      FSS_NORMAL: begin
        next_r.mode = FSS_NORMAL;
      end
      FSS_SAFE_OFF: begin
        next_r.vddEnable = 1'b0;
        next_r.resetOutN = 1'b0;
        if (wake) begin
          // Safe output stays low here; only the clear command frees it
          next_r.vddEnable = 1'b1;
          next_r.mode = FSS_RESET;
          next_r.safeState = 1'b0;
          next_r.failCount = 4'h0;
          next_r.timerRestart = 1'b1;
        end
      end
      default: begin
        next_r.mode = FSS_OFF;
        next_r.vddEnable = 1'b0;
      end
    endcase
    // Missed refresh: short reset pulse, then the window starts again
    if (operating && timerDone) begin
      next_r.mode = (r.mode == FSS_INIT) ? FSS_INIT_RESET : FSS_RESET;
      next_r.resetOutN = 1'b0;
      next_r.timerRestart = 1'b1;
      next_r.failCount = newCount;
      if (newCount == (r.secondPulse ? 4'h2 : 4'h1)) begin
        next_r.safeOutN = 1'b0;
      end
      if (newCount == `FSS_FAIL_LIMIT) begin
        next_r.safeState = 1'b1;
        next_r.safeOutN = 1'b0;
        next_r.io1WakeArmed = io1WakeEnable;
      end
    end
    // Supply under threshold takes priority over the watchdog
    if (operating && p.mcuSupplyLow) begin
      next_r.mode = FSS_RESET;
      next_r.resetOutN = 1'b0;
      next_r.safeOutN = 1'b0;
      next_r.timerRestart = 1'b1;
    end
    // External reset clamp
    if (enterSafe) begin
      next_r.safeState = 1'b1;
      next_r.safeOutN = 1'b0;
      next_r.io1WakeArmed = io1WakeEnable;
    end
    // Behaviour inside the safe state while the supply is still up
    if (r.safeState && (r.mode != FSS_SAFE_OFF)) begin
      next_r.safeOutN = 1'b0;
      if (recovered) begin
        next_r.safeState = 1'b0;
      end else if (vddOffCond) begin
        next_r.vddEnable = 1'b0;
        next_r.resetOutN = 1'b0;
        next_r.mode = FSS_SAFE_OFF;
      end
    end
    // Bus idle flag, held until traffic or safe exit
    if (p.canActivity || !r.safeState) begin
      next_r.busIdle = 1'b0;
    end else if (busDone) begin
      next_r.busIdle = 1'b1;
    end
    // Power-on reset always drops the supply; crank hold waits for it
    if (p.batteryPor) begin
      next_r.vddEnable = 1'b0;
      next_r.batteryFailFlag = 1'b1;
      next_r.resetOutN = 1'b0;
      next_r.mode = FSS_OFF;
      next_r.safeState = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      r <= '0;
      r.mode <= FSS_OFF;
      r.safeOutN <= 1'b1;
      r.crankHold <= 1'b0;
      r.miscSel <= `FSS_MISC_RESET;
      r.strapMode <= FSS_SAFE_A;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign vddEnable = r.vddEnable;
  assign resetPinOut = 1'b0; // Open drain: only ever pulls low
  assign resetPinOe = !r.resetOutN;
  assign safeOutN = r.safeOutN;
  assign resetSupplyThreshold = resetThresholdSel;
  assign batteryFailFlag = r.batteryFailFlag;
  assign safeStateActive = r.safeState;
  assign safeModeSel = effMode;
  assign failCount = r.failCount;
  assign deviceMode = r.mode;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence sWdExpire;
    operating && timerDone && !p.mcuSupplyLow && !enterSafe && !p.batteryPor;
  endsequence

  sequence sFirstFail;
    sWdExpire and (r.failCount == 4'h0) and !r.secondPulse;
  endsequence

  a_crank_reset: assert property (@(posedge core_clk) disable iff (1'b0)
    reset |=> !r.crankHold) else $error("crank hold not cleared by reset");
  a_power_on: assert property ((r.mode == FSS_OFF) && p.batteryAboveOn &&
    !p.batteryPor |=> r.vddEnable) else $error("supply not enabled at power up");
  a_reset_drop: assert property (inReset && !r.crankHold &&
    !p.batteryAboveOn |=> !r.vddEnable) else $error("supply kept in reset below threshold");
  a_por_fail: assert property (p.batteryPor |=>
    !r.vddEnable && r.batteryFailFlag) else $error("power-on reset not handled");
  a_safe_low: assert property (r.safeState && $past(r.safeState) |->
    !r.safeOutN) else $error("safe output high in safe state");
  a_mode_a_on: assert property (r.safeState && (effMode == FSS_SAFE_A) &&
    r.vddEnable && !p.batteryPor && p.batteryAboveOn |=> r.vddEnable)
    else $error("mode A dropped the supply");
  a_b2_off: assert property (r.safeState && (r.mode != FSS_SAFE_OFF) &&
    (effMode == FSS_SAFE_B2) && !p.io1Level && !recovered && !p.batteryPor |=>
    !r.vddEnable && (r.mode == FSS_SAFE_OFF)) else $error("mode B2 kept the supply");
  a_override_win: assert property (r.miscSel[2] |-> effMode ==
    (r.miscSel[1] ? (r.miscSel[0] ? FSS_SAFE_A : FSS_SAFE_B1) :
    (r.miscSel[0] ? FSS_SAFE_B2 : FSS_SAFE_B3))) else $error("override ignored");
  a_wake_reset: assert property ((r.mode == FSS_SAFE_OFF) && wake && !p.batteryPor |=>
    (r.mode == FSS_RESET) && r.vddEnable && !r.safeOutN) else $error("wake did not resume");
  a_safe_hold: assert property (!r.safeOutN && !clearCmd |=> !r.safeOutN)
    else $error("safe output released without clear");
  a_first_pulse: assert property (sFirstFail |=> !r.safeOutN && !r.resetOutN)
    else $error("safe not set at first pulse");
  a_second_pulse: assert property (sWdExpire and (r.failCount == 4'h1) and
    r.secondPulse |=> !r.safeOutN) else $error("safe not set at second pulse");
  a_vdd_low: assert property (operating && p.mcuSupplyLow |=>
    !r.safeOutN && !r.resetOutN && $fell(r.resetOutN)) else $error("supply low not paired");
  a_eight_fail: assert property (sWdExpire and (r.failCount == 4'h7) |=>
    r.safeState) else $error("eighth failure missed safe state");
  a_pulse_len: assert property (sWdExpire |=> !r.resetOutN [*8])
    else $error("reset pulse too short");
  a_count_clear: assert property (wdRefreshOk && !p.batteryPor |=>
    r.failCount == 4'h0) else $error("refresh did not clear failure count");

endmodule

// ==== fss_sync.sv ====
module fss_sync import fss_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Levels
  input wire fss_pins_t pinsAsync,
  output fss_pins_t pinsSync
);

  fss_sync_t r;
  fss_sync_t next_r;

  // Two stages per bit; only the second stage is read outside
  always_comb begin
    next_r = r;
    next_r.stage1 = pinsAsync;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pinsSync = r.stage2;

endmodule

// ==== fss_timer.sv ====
module fss_timer import fss_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control
  input wire logic restart,
  input wire logic enable,
  input wire logic [31:0] limit,
  // Expiry
  output logic done
);

  fss_timer_t r;
  fss_timer_t next_r;

  // Pulse on the last cycle of the span; a restart always wins
  assign done = enable && !restart && (r.count == limit - 32'h0000_0001);

  // Count runs while enabled and wraps on expiry so spans repeat; a restart or disable clears it
  always_comb begin
    next_r = r;
    if (restart || !enable || done) begin
      next_r.count = 32'h0000_0000;
    end else begin
      next_r.count = r.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

// ==== tb_fss_supervisor.sv ====
module tb_fss_supervisor import fss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Stimulus and wiring
  // ****************************************
  localparam logic [31:0] WD = 32'h0000_00C8;
  localparam logic [31:0] RST = 32'h0000_0014;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic batOn = 1'b0, por = 1'b0, supLow = 1'b0, io1 = 1'b1, can = 1'b0;
  fss_safe_t strap = FSS_SAFE_B1;
  logic wdInitWrite = 1'b0, miscInitWrite = 1'b0, keepAlive = 1'b0, thrSel = 1'b0;
  logic [7:0] wdInitData = 8'h00;
  logic [2:0] miscInitData = 3'h0;
  logic io1En = 1'b0, batClr = 1'b0, rstClamp = 1'b0;
  logic wdRefreshOk, spiCmdValid, vddEnable, resetPinOut, resetPinOe, safeOutN;
  logic resetSupplyThreshold, batteryFailFlag, safeStateActive;
  logic [15:0] spiCmd;
  logic [3:0] failCount;
  fss_safe_t safeModeSel;
  fss_mode_t deviceMode;
  fss_pins_t pins;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  logic [2:0] codes [4] = '{3'b111, 3'b110, 3'b100, 3'b101};
  fss_safe_t modes [4] = '{FSS_SAFE_A, FSS_SAFE_B1, FSS_SAFE_B3, FSS_SAFE_B2};

  // Reset line has a pull-up: low while the device pulls it or the clamp holds it
  assign pins = {batOn, por, supLow, !resetPinOe && !rstClamp, io1, can, 1'b0, strap};

  always #5 core_clk = ~core_clk;

  fss_supervisor #(.WD_PERIOD_CYC(WD), .RST_PULSE_CYC(RST), .BUS_IDLE_CYC(32'h0000_012C),
    .CLAMP_CYC(32'h0000_0064)) fss_supervisor_inst (.core_clk(core_clk), .reset(reset),
    .pinsAsync(pins), .wdInitWrite(wdInitWrite), .wdInitData(wdInitData),
    .miscInitWrite(miscInitWrite), .miscInitData(miscInitData), .wdRefreshOk(wdRefreshOk),
    .spiCmdValid(spiCmdValid), .spiCmd(spiCmd), .io1WakeEnable(io1En),
    .resetThresholdSel(thrSel), .batteryFailClear(batClr), .vddEnable(vddEnable),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .safeOutN(safeOutN),
    .resetSupplyThreshold(resetSupplyThreshold), .batteryFailFlag(batteryFailFlag),
    .safeStateActive(safeStateActive), .safeModeSel(safeModeSel), .failCount(failCount),
    .deviceMode(deviceMode));

  fss_host fss_host_inst (.core_clk(core_clk), .keepAlive(keepAlive),
    .wdRefreshOk(wdRefreshOk), .spiCmdValid(spiCmdValid), .spiCmd(spiCmd));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [3:0] probe(input int sel);
    case (sel)
      0: return {1'b0, deviceMode};
      1: return failCount;
      2: return {3'h0, safeStateActive};
      default: return {3'h0, vddEnable};
    endcase
  endfunction

  // Bounded wait on a status value, then one comparison
  task automatic wait_val(input int sel, input logic [3:0] v, input int lim);
    while (probe(sel) !== v && lim > 0) begin
      tick(1);
      lim--;
    end
    check({12'h000, probe(sel)}, {12'h000, v});
  endtask

  // Register writes travel as one-cycle pulses
  task automatic wr(input logic misc, input logic [7:0] d);
    wdInitWrite = !misc;
    miscInitWrite = misc;
    wdInitData = d;
    miscInitData = d[2:0];
    tick(1);
    wdInitWrite = 1'b0;
    miscInitWrite = 1'b0;
    tick(1);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, well above the longest expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 12000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    tick(3);
    reset = 1'b0;
    batOn = 1'b1;
    wait_val(3, 4'h1, 10);
    wait_val(0, {1'b0, FSS_INIT}, 40);
    fss_host_inst.refresh();
    keepAlive = 1'b1;
    wait_val(0, {1'b0, FSS_NORMAL}, 10);
    check(safeModeSel, FSS_SAFE_B1);
    thrSel = 1'b1;
    tick(1);
    check(resetSupplyThreshold, 1'b1);
    $display("Test power-up done");
    // Every override code, ending on B2 for the safe-state test
    for (int i = 0; i < 4; i++) begin
      wr(1'b1, {5'h00, codes[i]});
      check(safeModeSel, modes[i]);
    end
    $display("Test override done");
    keepAlive = 1'b0;
    wait_val(1, 4'h1, 250);
    check(safeOutN, 1'b0);
    tick(RST - 4);
    check(deviceMode, FSS_RESET);
    wait_val(0, {1'b0, FSS_NORMAL_REQ}, 8);
    fss_host_inst.refresh();
    tick(1);
    check(failCount, 4'h0);
    keepAlive = 1'b1;
    fss_host_inst.command(16'hDD01);
    tick(2);
    check(safeOutN, 1'b0);
    fss_host_inst.command(16'hDD80);
    tick(2);
    check(safeOutN, 1'b1);
    $display("Test watchdog done");
    wr(1'b0, 8'h10);
    keepAlive = 1'b0;
    wait_val(1, 4'h1, 250);
    check(safeOutN, 1'b1);
    wait_val(1, 4'h2, 250);
    check(safeOutN, 1'b0);
    wait_val(2, 4'h1, 1700);
    check(failCount, 4'h8);
    check(safeOutN, 1'b0);
    io1 = 1'b0;
    wait_val(0, {1'b0, FSS_SAFE_OFF}, 30);
    check(vddEnable, 1'b0);
    io1 = 1'b1;
    tick(10);
    check(deviceMode, FSS_SAFE_OFF);
    can = 1'b1;
    wait_val(0, {1'b0, FSS_RESET}, 6);
    can = 1'b0;
    check(vddEnable, 1'b1);
    check(safeOutN, 1'b0);
    wait_val(0, {1'b0, FSS_NORMAL_REQ}, 30);
    fss_host_inst.refresh();
    keepAlive = 1'b1;
    wait_val(2, 4'h0, 5);
    fss_host_inst.command(16'hDD00);
    tick(2);
    check(safeOutN, 1'b1);
    $display("Test safe state done");
    // Reset pin held low from outside: safe entry, recovery only once released
    rstClamp = 1'b1;
    wait_val(2, 4'h1, 120);
    fss_host_inst.refresh();
    tick(2);
    check(safeStateActive, 1'b1);
    rstClamp = 1'b0;
    tick(3);
    fss_host_inst.refresh();
    check(safeStateActive, 1'b0);
    check(safeOutN, 1'b0);
    fss_host_inst.command(16'hDD00);
    tick(2);
    check(safeOutN, 1'b1);
    // Second clamp in B3 with I/O-1 wake armed: supply drops only on both conditions
    wr(1'b1, 8'h04);
    io1En = 1'b1;
    rstClamp = 1'b1;
    wait_val(2, 4'h1, 120);
    io1 = 1'b0;
    tick(50);
    check(deviceMode, FSS_NORMAL);
    wait_val(0, {1'b0, FSS_SAFE_OFF}, 300);
    rstClamp = 1'b0;
    io1 = 1'b1;
    wait_val(0, {1'b0, FSS_RESET}, 6);
    check(vddEnable, 1'b1);
    wait_val(0, {1'b0, FSS_NORMAL}, 100);
    fss_host_inst.command(16'hDD80);
    tick(2);
    check(safeOutN, 1'b1);
    $display("Test clamp done");
    wr(1'b0, 8'h00);
    batOn = 1'b0;
    tick(10);
    check(vddEnable, 1'b1);
    supLow = 1'b1;
    tick(3);
    check(resetPinOe, 1'b1);
    check(safeOutN, 1'b0);
    wait_val(3, 4'h0, 5);
    keepAlive = 1'b0;
    supLow = 1'b0;
    batOn = 1'b1;
    wait_val(3, 4'h1, 20);
    wr(1'b0, 8'h01);
    batOn = 1'b0;
    tick(10);
    check(vddEnable, 1'b1);
    por = 1'b1;
    wait_val(3, 4'h0, 5);
    check(batteryFailFlag, 1'b1);
    por = 1'b0;
    tick(3);
    batClr = 1'b1;
    tick(1);
    batClr = 1'b0;
    tick(1);
    check(batteryFailFlag, 1'b0);
    $display("Test supply done");
    report_and_stop();
  end
endmodule
